// file: hw/cprs_defines.svh
// constants for the programmer-visible register set of an 8-bit core
// assumes inclusion by bare name from the design files
// Behaviour
// RULE1 - one 8-bit sum register feeding the alu, loadable and storable, untouched by reset
// RULE2 - 16-bit index pointer built from upper and lower bytes, full value for indexing
// RULE3 - reset clears upper pointer byte, lower pointer byte keeps its value
// RULE4 - some operations act on lower pointer byte only, upper byte untouched
// RULE5 - lower byte is a data register: clear, inc, dec, com, neg, shift, rotate, transfers
// RULE6 - 16-bit stack pointer addresses next free stack location anywhere in 64 Kbyte
// RULE7 - stack holds return address on calls, return address and registers on interrupts
// RULE8 - reset forces the stack pointer to 0x00ff
// RULE9 - stack adjust adds a sign-extended 8-bit immediate to the whole stack pointer
// RULE10 - stack low reload changes only the low byte of the stack pointer
// RULE11 - program counter advances by one on every instruction or operand byte fetch
// RULE12 - jump, branch, interrupt and return load a non-sequential program counter value
// RULE13 - reset loads the program counter from the vector at 0xfffe and 0xffff
// RULE14 - 8-bit flag register with mask and five flags, bits 6 and 5 read one
// RULE15 - core registers sit outside the memory map, reached only by execution
// RULE16 - flags: overflow 7, half-carry 4, mask 3, negative 2, zero 1, carry 0
// RULE17 - interrupt mask set after registers are stacked, before the first handler instruction
// RULE18 - vector high byte comes from the lower address, low byte from the next
`ifndef CPRS_DEFINES_SVH
`define CPRS_DEFINES_SVH
`define CPRS_SP_RESET      16'h00ff
`define CPRS_SP_LOW_RELOAD 8'hff
`define CPRS_VEC_HI_ADDR   16'hfffe
`define CPRS_VEC_LO_ADDR   16'hffff
`define CPRS_IDX_HI_RESET  8'h00
`define CPRS_PC_RESET      16'h0000
`define CPRS_FLAG_RESET    8'h68
`define CPRS_FLAG_V        7
`define CPRS_FLAG_ONE6     6
`define CPRS_FLAG_ONE5     5
`define CPRS_FLAG_H        4
`define CPRS_FLAG_I        3
`define CPRS_FLAG_N        2
`define CPRS_FLAG_Z        1
`define CPRS_FLAG_C        0
`define CPRS_FLAG_FIXED    8'h60
`endif

// file: hw/cprs_pkg.sv
// types shared by the register set and its helpers
// assumes cprs_defines.svh is compiled alongside
package cprs_pkg;
  // operations on the lower pointer byte
  typedef enum logic [3:0] {
    CPRS_XOP_NONE, CPRS_XOP_CLR, CPRS_XOP_INC, CPRS_XOP_DEC, CPRS_XOP_COM,
    CPRS_XOP_NEG, CPRS_XOP_LSL, CPRS_XOP_LSR, CPRS_XOP_ASR, CPRS_XOP_ROL,
    CPRS_XOP_ROR, CPRS_XOP_FROM_SUM
  } cprs_xop_t;
  // stack pointer operations
  typedef enum logic [2:0] {
    CPRS_SOP_NONE, CPRS_SOP_PUSH, CPRS_SOP_PULL, CPRS_SOP_ADJUST,
    CPRS_SOP_LOW_RELOAD, CPRS_SOP_LOAD
  } cprs_sop_t;
  // reset vector fetch sequence
  typedef enum logic [1:0] {
    CPRS_VS_HI, CPRS_VS_LO, CPRS_VS_RUN
  } cprs_vstate_t;
endpackage

// file: hw/cprs_xunit.sv
// lower pointer byte data unit: one-operand operations on an 8-bit value
// assumes combinational use from the register set, carry in from flags
module cprs_xunit (
  // operand
  input  wire logic [7:0]         x_in,
  input  wire logic [7:0]         sum_in,
  input  wire logic               carry_in,
  input  wire cprs_pkg::cprs_xop_t op,
  // result
  output logic      [7:0]         x_out,
  output logic                    carry_out,
  output logic                    carry_upd
);
  // RULE5 x data ops
  always_comb begin
    x_out     = x_in;
    carry_out = carry_in;
    carry_upd = 1'b0;
    case (op)
      cprs_pkg::CPRS_XOP_CLR:      x_out = 8'h00;
      cprs_pkg::CPRS_XOP_INC:      x_out = x_in + 8'h01;
      cprs_pkg::CPRS_XOP_DEC:      x_out = x_in - 8'h01;
      cprs_pkg::CPRS_XOP_COM: begin
        x_out = ~x_in;
        carry_out = 1'b1;
        carry_upd = 1'b1;
      end
      cprs_pkg::CPRS_XOP_NEG: begin
        x_out = 8'h00 - x_in;
        carry_out = (x_in != 8'h00);
        carry_upd = 1'b1;
      end
      cprs_pkg::CPRS_XOP_LSL: begin
        x_out = {x_in[6:0], 1'b0};
        carry_out = x_in[7];
        carry_upd = 1'b1;
      end
      cprs_pkg::CPRS_XOP_LSR: begin
        x_out = {1'b0, x_in[7:1]};
        carry_out = x_in[0];
        carry_upd = 1'b1;
      end
      cprs_pkg::CPRS_XOP_ASR: begin
        x_out = {x_in[7], x_in[7:1]};
        carry_out = x_in[0];
        carry_upd = 1'b1;
      end
      cprs_pkg::CPRS_XOP_ROL: begin
        x_out = {x_in[6:0], carry_in};
        carry_out = x_in[7];
        carry_upd = 1'b1;
      end
      cprs_pkg::CPRS_XOP_ROR: begin
        x_out = {carry_in, x_in[7:1]};
        carry_out = x_in[0];
        carry_upd = 1'b1;
      end
      cprs_pkg::CPRS_XOP_FROM_SUM: x_out = sum_in;
      default:                      x_out = x_in;
    endcase
  end
endmodule

// file: hw/cprs_spunit.sv
// stack pointer next-value logic
// assumes the register set holds the pointer and applies the result
`include "cprs_defines.svh"
module cprs_spunit (
  // current pointer and command
  input  wire logic [15:0]        sp_in,
  input  wire cprs_pkg::cprs_sop_t op,
  input  wire logic [7:0]         imm,
  input  wire logic [15:0]        load_val,
  // next pointer
  output logic      [15:0]        sp_out
);
  // stack grows down, push leaves pointer at next free byte
  always_comb begin
    case (op)
      // RULE6 push pull
      cprs_pkg::CPRS_SOP_PUSH:       sp_out = sp_in - 16'h0001;
      cprs_pkg::CPRS_SOP_PULL:       sp_out = sp_in + 16'h0001;
      // RULE9 signed adjust
      cprs_pkg::CPRS_SOP_ADJUST:     sp_out = sp_in + {{8{imm[7]}}, imm};
      // RULE10 low byte only
      cprs_pkg::CPRS_SOP_LOW_RELOAD: sp_out = {sp_in[15:8], `CPRS_SP_LOW_RELOAD};
      cprs_pkg::CPRS_SOP_LOAD:       sp_out = load_val;
      default:                       sp_out = sp_in;
    endcase
  end
endmodule

// file: hw/cprs_regs.sv
// programmer-visible register set: sum, index pointer, stack, program counter, flags
// assumes execution logic drives one-cycle commands on the core clock;
// registers have no memory address, only these ports reach them
`include "cprs_defines.svh"
module cprs_regs (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // memory read data for vector fetch
  input  wire logic [7:0]          mem_rdata,
  // sum register control
  input  wire logic                sum_load,
  input  wire logic [7:0]          sum_data,
  // index pointer control
  input  wire cprs_pkg::cprs_xop_t x_op,
  input  wire logic                idx_load,
  input  wire logic [15:0]         idx_data,
  input  wire logic                x_load,
  input  wire logic [7:0]          x_data,
  // stack pointer control
  input  wire cprs_pkg::cprs_sop_t sp_op,
  input  wire logic [7:0]          sp_imm,
  input  wire logic [15:0]         sp_data,
  // program counter control
  input  wire logic                pc_fetch,
  input  wire logic                pc_flow,
  input  wire logic [15:0]         pc_target,
  // flag control
  input  wire logic                flags_load,
  input  wire logic [7:0]          flags_data,
  input  wire logic                irq_stacked,
  // register views
  output logic [7:0]               sum_q,
  output logic [15:0]              index_pointer,
  output logic [15:0]              stack_pointer,
  output logic [15:0]              program_counter,
  output logic [7:0]               condition_flags,
  // vector fetch
  output logic [15:0]              vec_addr,
  output logic                     vec_rd,
  output logic                     core_ready
);
  // whole state in one struct
  typedef struct packed {
    logic [7:0]            sum;
    logic [7:0]            idx_hi;
    logic [7:0]            idx_lo;
    logic [15:0]           sp;
    logic [15:0]           pc;
    logic [7:0]            flags;
    cprs_pkg::cprs_vstate_t vs;
    logic [15:0]           vec_addr;
    logic                  vec_rd;
    logic                  ready;
  } cprs_state_t;

  cprs_state_t st_r;
  cprs_state_t st_nxt;
  logic [7:0]  x_res;
  logic        x_c;
  logic        x_cupd;
  logic [15:0] sp_res;

  // lower pointer byte data path
  cprs_xunit u_xunit (
    .x_in      (st_r.idx_lo),
    .sum_in    (st_r.sum),
    .carry_in  (st_r.flags[`CPRS_FLAG_C]),
    .op        (x_op),
    .x_out     (x_res),
    .carry_out (x_c),
    .carry_upd (x_cupd)
  );

  // stack pointer path
  cprs_spunit u_spunit (
    .sp_in    (st_r.sp),
    .op       (sp_op),
    .imm      (sp_imm),
    .load_val (sp_data),
    .sp_out   (sp_res)
  );

  // next state; vector fetch first, then ordinary execution
  always_comb begin
    st_nxt = st_r;
    case (st_r.vs)
      cprs_pkg::CPRS_VS_HI: begin
        // RULE18 high byte first
        st_nxt.pc[15:8] = mem_rdata;
        st_nxt.vec_addr = `CPRS_VEC_LO_ADDR;
        st_nxt.vs       = cprs_pkg::CPRS_VS_LO;
      end
      cprs_pkg::CPRS_VS_LO: begin
        // RULE13 vector low byte
        st_nxt.pc[7:0] = mem_rdata;
        st_nxt.vec_rd  = 1'b0;
        st_nxt.ready   = 1'b1;
        st_nxt.vs      = cprs_pkg::CPRS_VS_RUN;
      end
      cprs_pkg::CPRS_VS_RUN: begin
        // RULE1 sum load
        if (sum_load) begin
          st_nxt.sum = sum_data;
        end else if (x_op == cprs_pkg::CPRS_XOP_NONE && x_load) begin
          st_nxt.sum = st_r.sum;
        end
        // RULE2 full pointer load
        if (idx_load) begin
          st_nxt.idx_hi = idx_data[15:8];
          st_nxt.idx_lo = idx_data[7:0];
        // RULE4 low byte only
        end else if (x_load) begin
          st_nxt.idx_lo = x_data;
        end else begin
          // RULE5 x data ops
          st_nxt.idx_lo = x_res;
        end
        // RULE7 stacking moves pointer
        st_nxt.sp = sp_res;
        // RULE12 change of flow
        if (pc_flow) begin
          st_nxt.pc = pc_target;
        // RULE11 sequential fetch
        end else if (pc_fetch) begin
          st_nxt.pc = st_r.pc + 16'h0001;
        end
        if (flags_load) begin
          st_nxt.flags = flags_data;
        end else if (x_cupd) begin
          st_nxt.flags[`CPRS_FLAG_C] = x_c;
        end
        // RULE17 mask after stacking
        if (irq_stacked) begin
          st_nxt.flags[`CPRS_FLAG_I] = 1'b1;
        end
      end
      default: st_nxt.vs = cprs_pkg::CPRS_VS_RUN;
    endcase
    // RULE14 fixed one bits
    st_nxt.flags = st_nxt.flags | `CPRS_FLAG_FIXED;
  end

  // register; reset touches only pointer high, stack, pc, flags and the fetch sequence
  // RULE1 sum kept over reset
  // RULE3 lower byte kept over reset
  // sum and low byte sit outside the reset branch, so they hold while reset is low;
  // this costs a hold path on those flops but keeps one register process
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // RULE3 upper byte cleared
      st_r.idx_hi   <= `CPRS_IDX_HI_RESET;
      // RULE8 stack reset value
      st_r.sp       <= `CPRS_SP_RESET;
      st_r.pc       <= `CPRS_PC_RESET;
      st_r.flags    <= `CPRS_FLAG_RESET;
      st_r.vs       <= cprs_pkg::CPRS_VS_HI;
      st_r.vec_addr <= `CPRS_VEC_HI_ADDR;
      st_r.vec_rd   <= 1'b1;
      st_r.ready    <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // RULE15 port views only
  assign sum_q           = st_r.sum;
  assign index_pointer   = {st_r.idx_hi, st_r.idx_lo};
  assign stack_pointer   = st_r.sp;
  assign program_counter = st_r.pc;
  // RULE16 flag layout
  assign condition_flags = st_r.flags;
  assign vec_addr        = st_r.vec_addr;
  assign vec_rd          = st_r.vec_rd;
  assign core_ready      = st_r.ready;

  // checks
  chk_sp_reset_val: assert property (@(posedge clk)
    $rose(rst_n) |-> stack_pointer == `CPRS_SP_RESET) // RULE8
    else $error("stack pointer not at reset value");
  chk_hi_reset_zero: assert property (@(posedge clk)
    $rose(rst_n) |-> index_pointer[15:8] == 8'h00) // RULE3
    else $error("pointer high byte not cleared");
  chk_pc_vector: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.vs == cprs_pkg::CPRS_VS_HI ##1 st_r.vs == cprs_pkg::CPRS_VS_LO
    |=> program_counter == {$past(mem_rdata, 2), $past(mem_rdata)}) // RULE13
    else $error("reset vector not loaded");
  chk_pc_increment: assert property (@(posedge clk) disable iff (!rst_n)
    core_ready && pc_fetch && !pc_flow
    |=> program_counter == $past(program_counter) + 16'h0001) // RULE11
    else $error("pc did not advance");
  chk_pc_flow: assert property (@(posedge clk) disable iff (!rst_n)
    core_ready && pc_flow |=> program_counter == $past(pc_target)) // RULE12
    else $error("pc not loaded on change of flow");
  chk_sp_adjust: assert property (@(posedge clk) disable iff (!rst_n)
    core_ready && sp_op == cprs_pkg::CPRS_SOP_ADJUST
    |=> stack_pointer == $past(stack_pointer) + {{8{$past(sp_imm[7])}}, $past(sp_imm)}) // RULE9
    else $error("stack adjust wrong");
  chk_sp_reload: assert property (@(posedge clk) disable iff (!rst_n)
    core_ready && sp_op == cprs_pkg::CPRS_SOP_LOW_RELOAD
    |=> stack_pointer == {$past(stack_pointer[15:8]), 8'hff}) // RULE10
    else $error("reload touched high byte");
  chk_flags_fixed: assert property (@(posedge clk) disable iff (!rst_n)
    condition_flags[6:5] == 2'b11) // RULE14
    else $error("fixed flag bits not one");
  chk_mask_set: assert property (@(posedge clk) disable iff (!rst_n)
    core_ready && irq_stacked |=> condition_flags[`CPRS_FLAG_I]) // RULE17
    else $error("mask not set after stacking");
  chk_x_only: assert property (@(posedge clk) disable iff (!rst_n)
    core_ready && !idx_load |=> index_pointer[15:8] == $past(index_pointer[15:8])) // RULE4
    else $error("upper byte changed");
  chk_sp_push: assert property (@(posedge clk) disable iff (!rst_n)
    core_ready && sp_op == cprs_pkg::CPRS_SOP_PUSH
    |=> stack_pointer == $past(stack_pointer) - 16'h0001) // RULE7
    else $error("push did not step pointer");
  chk_sum_load: assert property (@(posedge clk) disable iff (!rst_n)
    core_ready && sum_load |=> sum_q == $past(sum_data)) // RULE1
    else $error("sum register not loaded");

  // stack pointer commands
  chk_sp_pull: assert property (@(posedge clk) disable iff (!rst_n)
    core_ready && sp_op == cprs_pkg::CPRS_SOP_PULL
    |=> stack_pointer == $past(stack_pointer) + 16'h0001) // RULE6
    else $error("pull did not step pointer");
  chk_sp_load: assert property (@(posedge clk) disable iff (!rst_n)
    core_ready && sp_op == cprs_pkg::CPRS_SOP_LOAD |=> stack_pointer == $past(sp_data)) // RULE6
    else $error("stack pointer not loaded");
  chk_sp_hold: assert property (@(posedge clk) disable iff (!rst_n)
    core_ready && sp_op == cprs_pkg::CPRS_SOP_NONE |=> stack_pointer == $past(stack_pointer)) // RULE6
    else $error("idle stack pointer moved");

  // index pointer loads; sum and low byte may be unknown before their first load,
  // so none of these checks looks at them before a command gives them a value
  chk_idx_load: assert property (@(posedge clk) disable iff (!rst_n)
    core_ready && idx_load |=> index_pointer == $past(idx_data)) // RULE2
    else $error("index pointer not loaded");
  chk_x_load: assert property (@(posedge clk) disable iff (!rst_n)
    core_ready && !idx_load && x_load |=> index_pointer[7:0] == $past(x_data)) // RULE4
    else $error("low byte not loaded");

  // one-operand operations on the low byte
  chk_x_clear: assert property (@(posedge clk) disable iff (!rst_n)
    core_ready && !idx_load && !x_load && x_op == cprs_pkg::CPRS_XOP_CLR
    |=> index_pointer[7:0] == 8'h00) // RULE5
    else $error("low byte not cleared");
  chk_x_from_sum: assert property (@(posedge clk) disable iff (!rst_n)
    core_ready && !idx_load && !x_load && x_op == cprs_pkg::CPRS_XOP_FROM_SUM
    |=> index_pointer[7:0] == $past(sum_q)) // RULE5
    else $error("transfer from sum wrong");
  chk_x_inc: assert property (@(posedge clk) disable iff (!rst_n)
    core_ready && !idx_load && !x_load && x_op == cprs_pkg::CPRS_XOP_INC
    |=> index_pointer[7:0] == $past(index_pointer[7:0]) + 8'h01) // RULE5
    else $error("low byte increment wrong");
  chk_x_dec: assert property (@(posedge clk) disable iff (!rst_n)
    core_ready && !idx_load && !x_load && x_op == cprs_pkg::CPRS_XOP_DEC
    |=> index_pointer[7:0] == $past(index_pointer[7:0]) - 8'h01) // RULE5
    else $error("low byte decrement wrong");
  chk_x_com: assert property (@(posedge clk) disable iff (!rst_n)
    core_ready && !idx_load && !x_load && x_op == cprs_pkg::CPRS_XOP_COM
    |=> index_pointer[7:0] == ~$past(index_pointer[7:0])) // RULE5
    else $error("low byte complement wrong");
  chk_x_neg: assert property (@(posedge clk) disable iff (!rst_n)
    core_ready && !idx_load && !x_load && x_op == cprs_pkg::CPRS_XOP_NEG
    |=> index_pointer[7:0] == 8'h00 - $past(index_pointer[7:0])) // RULE5
    else $error("low byte negate wrong");
  chk_x_lsl: assert property (@(posedge clk) disable iff (!rst_n)
    core_ready && !idx_load && !x_load && x_op == cprs_pkg::CPRS_XOP_LSL
    |=> index_pointer[7:0] == {$past(index_pointer[6:0]), 1'b0}) // RULE5
    else $error("low byte left shift wrong");
  chk_x_lsr: assert property (@(posedge clk) disable iff (!rst_n)
    core_ready && !idx_load && !x_load && x_op == cprs_pkg::CPRS_XOP_LSR
    |=> index_pointer[7:0] == {1'b0, $past(index_pointer[7:1])}) // RULE5
    else $error("low byte right shift wrong");
  chk_x_asr: assert property (@(posedge clk) disable iff (!rst_n)
    core_ready && !idx_load && !x_load && x_op == cprs_pkg::CPRS_XOP_ASR
    |=> index_pointer[7:0] == {$past(index_pointer[7]), $past(index_pointer[7:1])}) // RULE5
    else $error("low byte arithmetic shift wrong");
  chk_x_rol: assert property (@(posedge clk) disable iff (!rst_n)
    core_ready && !idx_load && !x_load && x_op == cprs_pkg::CPRS_XOP_ROL
    |=> index_pointer[7:0] == {$past(index_pointer[6:0]), $past(condition_flags[0])}) // RULE5
    else $error("low byte left rotate wrong");
  chk_x_ror: assert property (@(posedge clk) disable iff (!rst_n)
    core_ready && !idx_load && !x_load && x_op == cprs_pkg::CPRS_XOP_ROR
    |=> index_pointer[7:0] == {$past(condition_flags[0]), $past(index_pointer[7:1])}) // RULE5
    else $error("low byte right rotate wrong");
  chk_carry_com: assert property (@(posedge clk) disable iff (!rst_n)
    core_ready && !flags_load && x_op == cprs_pkg::CPRS_XOP_COM
    |=> condition_flags[`CPRS_FLAG_C]) // RULE16
    else $error("complement left carry clear");

  // program counter and flags
  chk_pc_hold: assert property (@(posedge clk) disable iff (!rst_n)
    core_ready && !pc_fetch && !pc_flow |=> program_counter == $past(program_counter)) // RULE11
    else $error("pc moved without a fetch");
  chk_flags_load: assert property (@(posedge clk) disable iff (!rst_n)
    core_ready && flags_load && !irq_stacked
    |=> condition_flags == ($past(flags_data) | `CPRS_FLAG_FIXED)) // RULE16
    else $error("flags not loaded");

  // reset vector fetch; commands must stay ignored until it is done
  chk_vec_first: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.vs == cprs_pkg::CPRS_VS_HI |-> vec_addr == `CPRS_VEC_HI_ADDR && vec_rd) // RULE18
    else $error("vector fetch not at high byte");
  chk_vec_low: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.vs == cprs_pkg::CPRS_VS_LO |-> vec_addr == `CPRS_VEC_LO_ADDR && vec_rd) // RULE18
    else $error("vector fetch not at low byte");
  chk_ready_hold: assert property (@(posedge clk) disable iff (!rst_n)
    core_ready |=> core_ready) // RULE13
    else $error("ready dropped without reset");
  chk_busy_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    !core_ready |=> stack_pointer == $past(stack_pointer)) // RULE13
    else $error("command taken during vector fetch");

  cov_vector_done: cover property (@(posedge clk) disable iff (!rst_n) $rose(core_ready));
  cov_adjust: cover property (@(posedge clk) disable iff (!rst_n)
    core_ready && sp_op == cprs_pkg::CPRS_SOP_ADJUST && sp_imm[7]);
  cov_irq: cover property (@(posedge clk) disable iff (!rst_n) core_ready && irq_stacked);
  cov_rotate: cover property (@(posedge clk) disable iff (!rst_n)
    core_ready && x_op == cprs_pkg::CPRS_XOP_ROL);
  cov_sp_load: cover property (@(posedge clk) disable iff (!rst_n)
    core_ready && sp_op == cprs_pkg::CPRS_SOP_LOAD);
endmodule

// file: dv/cprs_mem_model.sv
// memory stand-in that answers the reset vector fetch of the register set
// assumes one byte is read per cycle while the read strobe is high
module cprs_mem_model #(
  parameter logic [15:0] VEC = 16'h8c41
) (
  // clock and fetch request
  input  wire logic        clk,
  input  wire logic [15:0] vec_addr,
  input  wire logic        vec_rd,
  // returned byte
  output logic      [7:0]  mem_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] junk_r = 8'h3c;
  // idle bus shows a moving pattern so a stale byte never passes for data
  always @(posedge clk) begin
    junk_r <= junk_r + 8'h5b;
  end
  always_comb begin
    if (!vec_rd) mem_rdata = junk_r;
    else if (vec_addr == 16'hfffe) mem_rdata = VEC[15:8];
    else if (vec_addr == 16'hffff) mem_rdata = VEC[7:0];
    else mem_rdata = ~junk_r;
  end
endmodule

// file: dv/tb_top.sv
// self-checking bench for the programmer-visible register set
// assumes the memory model supplies the reset vector; commands follow core_ready
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] VEC = 16'h8c41;
  logic clk, rst_n, sum_load, idx_load, x_load, pc_fetch, pc_flow, flags_load, irq_stacked;
  logic [7:0] mem_rdata, sum_data, x_data, sp_imm, flags_data, sum_q, condition_flags;
  logic [15:0] idx_data, sp_data, pc_target, index_pointer, stack_pointer, program_counter;
  logic [15:0] vec_addr, e_idx, e_sp, e_pc;
  logic [7:0] e_sum, imm, fd, e_fl;
  logic vec_rd, core_ready;
  logic [31:0] r, seed = 32'd95793;
  cprs_pkg::cprs_xop_t x_op, op;
  cprs_pkg::cprs_sop_t sp_op;
  int errors, compares;
  cprs_regs uut (.clk(clk), .rst_n(rst_n), .mem_rdata(mem_rdata), .sum_load(sum_load),
    .sum_data(sum_data), .x_op(x_op), .idx_load(idx_load), .idx_data(idx_data),
    .x_load(x_load), .x_data(x_data), .sp_op(sp_op), .sp_imm(sp_imm), .sp_data(sp_data),
    .pc_fetch(pc_fetch), .pc_flow(pc_flow), .pc_target(pc_target), .flags_load(flags_load),
    .flags_data(flags_data), .irq_stacked(irq_stacked), .sum_q(sum_q),
    .index_pointer(index_pointer), .stack_pointer(stack_pointer),
    .program_counter(program_counter), .condition_flags(condition_flags),
    .vec_addr(vec_addr), .vec_rd(vec_rd), .core_ready(core_ready));
  cprs_mem_model #(.VEC(VEC)) mem (.clk(clk), .vec_addr(vec_addr), .vec_rd(vec_rd),
    .mem_rdata(mem_rdata));
  // xorshift keeps the run repeatable
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected lower pointer byte after one operation
  function automatic logic [7:0] x_exp(cprs_pkg::cprs_xop_t o, logic [7:0] x, logic [7:0] s,
                                       logic c);
    case (o)
      cprs_pkg::CPRS_XOP_CLR:      return 8'h00;
      cprs_pkg::CPRS_XOP_INC:      return x + 8'h01;
      cprs_pkg::CPRS_XOP_DEC:      return x - 8'h01;
      cprs_pkg::CPRS_XOP_COM:      return ~x;
      cprs_pkg::CPRS_XOP_NEG:      return 8'h00 - x;
      cprs_pkg::CPRS_XOP_LSL:      return {x[6:0], 1'b0};
      cprs_pkg::CPRS_XOP_LSR:      return {1'b0, x[7:1]};
      cprs_pkg::CPRS_XOP_ASR:      return {x[7], x[7:1]};
      cprs_pkg::CPRS_XOP_ROL:      return {x[6:0], c};
      cprs_pkg::CPRS_XOP_ROR:      return {c, x[7:1]};
      cprs_pkg::CPRS_XOP_FROM_SUM: return s;
      default:                     return x;
    endcase
  endfunction
  // expected carry after one low-byte operation
  function automatic logic c_exp(cprs_pkg::cprs_xop_t o, logic [7:0] x, logic c);
    case (o)
      cprs_pkg::CPRS_XOP_COM:                         return 1'b1;
      cprs_pkg::CPRS_XOP_NEG:                         return x != 8'h00;
      cprs_pkg::CPRS_XOP_LSL, cprs_pkg::CPRS_XOP_ROL: return x[7];
      cprs_pkg::CPRS_XOP_LSR, cprs_pkg::CPRS_XOP_ASR,
      cprs_pkg::CPRS_XOP_ROR:                         return x[0];
      default:                                        return c;
    endcase
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // bounded wait for the vector fetch to finish
  task automatic wait_ready;
    int n;
    n = 0;
    while (core_ready !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({15'h0, core_ready}, 16'h0001);
    if (core_ready !== 1'b1) final_report;
  endtask
  // lets the staged command be sampled, then drops every pulse
  task automatic fin;
    @(posedge clk);
    sum_load <= 1'b0;
    idx_load <= 1'b0;
    x_load <= 1'b0;
    x_op <= cprs_pkg::CPRS_XOP_NONE;
    sp_op <= cprs_pkg::CPRS_SOP_NONE;
    pc_fetch <= 1'b0;
    pc_flow <= 1'b0;
    flags_load <= 1'b0;
    irq_stacked <= 1'b0;
    #1;
  endtask
  // 40 MHz core clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {rst_n, sum_load, idx_load, x_load, pc_fetch, pc_flow, flags_load, irq_stacked} = '0;
    {sum_data, x_data, sp_imm, flags_data, idx_data, sp_data, pc_target} = '0;
    x_op = cprs_pkg::CPRS_XOP_NONE;
    sp_op = cprs_pkg::CPRS_SOP_NONE;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    wait_ready;
    chk({8'h00, index_pointer[15:8]}, 16'h0000);
    chk(stack_pointer, 16'h00ff);
    chk(program_counter, VEC);
    chk({8'h00, condition_flags & 8'h60}, 16'h0060);
    chk({15'h0, vec_rd}, 16'h0000);
    e_sp = 16'h00ff;
    e_pc = VEC;
    for (int i = 1; i < 12; i++) begin
      r = rnd();
      imm = (i == 1) ? 8'h80 : (i == 2) ? 8'h7f : r[7:0];
      // full loads, stack adjust and a fetch in one cycle
      @(posedge clk);
      sum_load <= 1'b1;
      sum_data <= r[7:0];
      idx_load <= 1'b1;
      idx_data <= r[31:16];
      sp_op <= cprs_pkg::CPRS_SOP_ADJUST;
      sp_imm <= imm;
      pc_fetch <= 1'b1;
      flags_load <= 1'b1;
      flags_data <= r[15:8];
      fin;
      e_sum = r[7:0];
      e_idx = r[31:16];
      e_sp = e_sp + {{8{imm[7]}}, imm};
      e_pc = e_pc + 16'h0001;
      chk({8'h00, sum_q}, {8'h00, e_sum});
      chk(index_pointer, e_idx);
      chk(stack_pointer, e_sp);
      chk(program_counter, e_pc);
      chk({8'h00, condition_flags}, {8'h00, r[15:8] | 8'h60});
      r = rnd();
      fd = r[15:8];
      // low byte load, stack low reload, jump that beats a fetch
      @(posedge clk);
      x_load <= 1'b1;
      x_data <= r[7:0];
      flags_load <= 1'b1;
      flags_data <= fd;
      sp_op <= cprs_pkg::CPRS_SOP_LOW_RELOAD;
      pc_fetch <= 1'b1;
      pc_flow <= 1'b1;
      pc_target <= r[31:16];
      fin;
      e_idx[7:0] = r[7:0];
      e_sp[7:0] = 8'hff;
      e_pc = r[31:16];
      chk(index_pointer, e_idx);
      chk(stack_pointer, e_sp);
      chk(program_counter, e_pc);
      op = cprs_pkg::cprs_xop_t'(i);
      // data op on the low byte, stack step, mask set on interrupt entry
      @(posedge clk);
      x_op <= op;
      sp_op <= i[0] ? cprs_pkg::CPRS_SOP_PUSH : cprs_pkg::CPRS_SOP_PULL;
      irq_stacked <= 1'b1;
      flags_load <= 1'b1;
      flags_data <= 8'h00;
      fin;
      e_idx[7:0] = x_exp(op, e_idx[7:0], e_sum, fd[0]);
      e_sp = i[0] ? e_sp - 16'h0001 : e_sp + 16'h0001;
      chk(index_pointer, e_idx);
      chk(stack_pointer, e_sp);
      chk({15'h0, condition_flags[3]}, 16'h0001);
      r = rnd();
      // whole stack load, data op whose carry lands in the flags
      @(posedge clk);
      x_op <= op;
      sp_op <= cprs_pkg::CPRS_SOP_LOAD;
      sp_data <= r[31:16];
      fin;
      e_fl = {7'h34, c_exp(op, e_idx[7:0], 1'b0)};
      e_idx[7:0] = x_exp(op, e_idx[7:0], e_sum, 1'b0);
      e_sp = r[31:16];
      chk(index_pointer, e_idx);
      chk({8'h00, condition_flags}, {8'h00, e_fl});
      chk(stack_pointer, e_sp);
      chk(program_counter, e_pc);
    end
    // second reset in mid-run: sum and low byte survive it
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({8'h00, sum_q}, {8'h00, e_sum});
    chk(index_pointer, {8'h00, e_idx[7:0]});
    chk(stack_pointer, 16'h00ff);
    chk(vec_addr, 16'hfffe);
    chk({15'h0, vec_rd}, 16'h0001);
    @(posedge clk);
    rst_n <= 1'b1;
    wait_ready;
    chk(program_counter, VEC);
    final_report;
  end
endmodule
